// *** verilog/ie_regs.svh ***
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the enhancement stream design files
`ifndef IE_REGS_SVH
`define IE_REGS_SVH

// Register offsets on the plain register port
`define IE_CTRL_OFF      8'h00
`define IE_ROWS_OFF      8'h04
`define IE_LINE_OFF      8'h08
`define IE_STAT_OFF      8'h0C

// Control register fields and register reset values
`define IE_CTRL_NR_BIT   0
`define IE_CTRL_EE_BIT   1
`define IE_CTRL_AA_BIT   2
`define IE_CTRL_HP_BIT   3
`define IE_CTRL_RST      4'h3
`define IE_ROWS_RST      16'h0020

// Latency figures in core clock cycles and in whole lines
`define IE_LAT_NR        6'h16
`define IE_LAT_EE        6'h14
`define IE_LAT_BOTH      6'h18
`define IE_LAT_AA        6'h03
`define IE_LAT_HP        6'h0B
`define IE_LINES_BASE    3'h2
`define IE_LINES_HP      3'h2
`define IE_PIPE_MAX      38

// Line store and output buffer sizes
`define IE_MEM_DEPTH     512
`define IE_MEM_AW        9
`define IE_FIFO_DEPTH    8

`endif

// *** verilog/ie_pkg.sv ***
// Types shared by the enhancement stream timing design
// Assumes nothing beyond a SystemVerilog compiler
package ie_pkg;

  // One stream beat: frame start, line end and a pixel word
  typedef struct packed {
    logic        user;
    logic        last;
    logic [23:0] pix;
  } ie_beat_t;

  typedef enum logic [1:0] {
    IE_RUN         = 2'b00,
    IE_FRAME_FLUSH = 2'b01
  } ie_state_t;

endpackage : ie_pkg

// *** verilog/ie_strm_if.sv ***
// Valid/ready carrier between the timing core and its output buffer
// Assumes both ends share one clock
interface ie_strm_if;
  logic             valid;
  logic             ready;
  ie_pkg::ie_beat_t data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ie_strm_if

// *** verilog/ie_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
// Assumes one clock, synchronous active-low reset and a freezing clock enable
module ie_fifo #(
  parameter int W     = 26,
  parameter int DEPTH = 8
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  ie_strm_if.snk    in_p,
  ie_strm_if.src    out_p
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]   cnt_reg, cnt_next;
  logic          push, pop;

  // Handshakes only count while the clock enable is high
  assign in_p.ready  = ce && (cnt_reg != (AW+1)'(DEPTH)); // [RULE8]
  assign out_p.valid = ce && (cnt_reg != '0);
  assign out_p.data  = mem_reg[rd_reg];
  assign push        = in_p.valid && in_p.ready;
  assign pop         = out_p.valid && out_p.ready;

  // Pointer and fill arithmetic
  always_comb
  begin
    wr_next  = push ? AW'((wr_reg + 1'b1) % DEPTH) : wr_reg;
    rd_next  = pop  ? AW'((rd_reg + 1'b1) % DEPTH) : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Storage has no reset; only the pointers need a defined start
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else if (ce)
    begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem_reg[wr_reg] <= in_p.data;
  end

  // A buffer with room must never turn the pipe away
  AST_FIFO_ROOM: assert property (@(posedge clk) disable iff (!rst_b) // [RULE8]
    ce && cnt_reg < (AW+1)'(DEPTH) |-> in_p.ready) else $error("buffer refused with room");

endmodule : ie_fifo

// *** verilog/ie_core.sv ***
// Stream timing core of the noise-reduction and edge-enhancement filter
// Assumes video-stream partners on both sides and one 100 MHz core clock
// How it works
// RULE1: One line is cycles between line ends
// RULE2: Noise only: two lines plus 22 cycles
// RULE3: Edge only: two lines plus 20, anti-alias +3
// RULE4: Both, small build: two lines plus 24, +3
// RULE5: Fast build adds two lines, 11 cycles
// RULE6: Exactly one output pixel per input sample
// RULE7: No input: drain buffers, then drop valid; mid-frame the line store keeps its last lines until the frame flush
// RULE8: Output stalled: fill buffers, then drop ready
// RULE9: One sample in, one out per cycle
// RULE10: After each line, flush with ready low
// RULE11: After each frame, one-line flush, ready low
// RULE12: Overhead at most 38 cycles, 4 lines
// RULE13: Streams follow video stream conventions
// RULE14: Source should send timed video ideally
// RULE15: Synchronous active-low reset of all logic; line store, pipe data stages past the first and buffer storage have none
// RULE16: State advances only with clock enable
// RULE17: First pixel user-marked, line end last-marked
`include "ie_regs.svh"
module ie_core (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [23:0] s_axis_video_tdata,
  input  wire logic        s_axis_video_tuser,
  input  wire logic        s_axis_video_tlast,
  input  wire logic        s_axis_video_tvalid,
  output logic             s_axis_video_tready,
  output logic      [23:0] m_axis_video_tdata,
  output logic             m_axis_video_tuser,
  output logic             m_axis_video_tlast,
  output logic             m_axis_video_tvalid,
  input  wire logic        m_axis_video_tready
);
  // Pipe length covers the longest figure, fast build with anti-alias
  localparam int PM = `IE_PIPE_MAX;
  localparam int MD = `IE_MEM_DEPTH;
  localparam int AW = `IE_MEM_AW;

  // Cycle part of the latency for a control setting
  function automatic logic [5:0] lat_cycles(input logic [3:0] c);
    logic [5:0] k;
    k = `IE_LAT_NR;
    if (c[`IE_CTRL_NR_BIT] && c[`IE_CTRL_EE_BIT])
    begin
      k = `IE_LAT_BOTH; // [RULE4]
      if (c[`IE_CTRL_HP_BIT])
        k = k + `IE_LAT_HP; // [RULE5]
    end
    else if (c[`IE_CTRL_EE_BIT])
      k = `IE_LAT_EE; // [RULE3]
    if (c[`IE_CTRL_EE_BIT] && c[`IE_CTRL_AA_BIT])
      k = k + `IE_LAT_AA;
    return k; // [RULE2]
  endfunction : lat_cycles

  // Whole-line part of the latency for a control setting
  // Lines are counted in the store, so a sample waits for later line ends
  function automatic logic [2:0] lat_lines(input logic [3:0] c);
    logic [2:0] n;
    n = `IE_LINES_BASE;
    if (c[`IE_CTRL_NR_BIT] && c[`IE_CTRL_EE_BIT] && c[`IE_CTRL_HP_BIT])
      n = n + `IE_LINES_HP; // [RULE5]
    return n;
  endfunction : lat_lines

  // Stream state, line store, cycle pipe and register file
  ie_pkg::ie_state_t state_reg, state_next;
  ie_pkg::ie_beat_t  mem_reg [MD];
  ie_pkg::ie_beat_t  pipe_d_reg [PM];
  ie_pkg::ie_beat_t  pipe_d_next [PM];
  ie_pkg::ie_beat_t  in_beat;
  logic [PM-1:0]     pipe_v_reg, pipe_v_next;
  logic [3:0]        ctrl_reg, ctrl_next;
  logic [15:0]       rows_reg, rows_next, row_reg, row_next;
  logic [31:0]       line_reg, line_next, cyc_reg, cyc_next;
  logic [31:0]       fflush_reg, fflush_next, rdata_reg, rdata_next;
  logic [5:0]        lflush_reg, lflush_next, k;
  logic [2:0]        dl;
  logic [AW-1:0]     wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]       cnt_reg, cnt_next;
  logic [AW:0]       lines_reg, lines_next;
  logic              eol_seen_reg, eol_seen_next;
  logic              in_fire, rd_fire, adv, tap_v, end_of_line_pulse, frame_end;
  ie_pkg::ie_beat_t  tap_d;

  // Carriers between the cycle pipe, the output buffer and the pins
  ie_strm_if pipe_to_buf ();
  ie_strm_if buf_to_out ();

  // Figures follow the control word; change it only between frames
  assign k   = lat_cycles(ctrl_reg);
  assign dl  = lat_lines(ctrl_reg);

  // Input handshake: closed by either flush or a full line store
  assign s_axis_video_tready = ce && (state_reg == ie_pkg::IE_RUN) // [RULE11]
                               && (lflush_reg == 6'h00) // [RULE10]
                               && (cnt_reg != (AW+1)'(MD)); // [RULE8]
  assign in_fire           = s_axis_video_tvalid && s_axis_video_tready; // [RULE9]
  assign end_of_line_pulse = in_fire && s_axis_video_tlast; // [RULE17]
  assign frame_end         = end_of_line_pulse && (row_reg + 16'h0001 >= rows_reg);
  assign in_beat           = '{user: s_axis_video_tuser, last: s_axis_video_tlast,
                               pix: s_axis_video_tdata};

  // Cycle pipe moves as a whole unless its tap is blocked by the buffer
  assign tap_v = pipe_v_reg[k - 6'h01];
  assign tap_d = pipe_d_reg[k - 6'h01];
  assign adv   = ce && (!tap_v || pipe_to_buf.ready);
  // A sample leaves the line store once enough whole lines follow it
  assign rd_fire = adv && (cnt_reg != '0)
                   && ((lines_reg > (AW+1)'(dl))
                       || (state_reg == ie_pkg::IE_FRAME_FLUSH)); // [RULE7]

  assign pipe_to_buf.valid = ce && tap_v;
  assign pipe_to_buf.data  = tap_d;

  // Cycle delay stages, one per core cycle while advancing
  always_comb
  begin
    pipe_v_next    = pipe_v_reg;
    pipe_d_next    = pipe_d_reg;
    if (adv)
    begin
      pipe_v_next    = {pipe_v_reg[PM-2:0], rd_fire};
      pipe_d_next[0] = mem_reg[rp_reg];
    end
  end

  // Data stages past the first carry no reset; only the valid bits and stage 0 get a known start
  generate
    for (genvar g = 1; g < PM; g++)
    begin : g_pipe
      always_ff @(posedge clk)
      begin
        if (adv)
          pipe_d_reg[g] <= pipe_d_reg[g-1];
      end
    end
  endgenerate

  // Line store bookkeeping and flush timing
  always_comb
  begin
    state_next    = state_reg;
    wp_next       = in_fire ? AW'(wp_reg + 1'b1) : wp_reg;
    rp_next       = rd_fire ? AW'(rp_reg + 1'b1) : rp_reg;
    cnt_next      = cnt_reg + (AW+1)'(in_fire) - (AW+1)'(rd_fire); // [RULE6]
    lines_next    = lines_reg + (AW+1)'(end_of_line_pulse)
                    - (AW+1)'(rd_fire && mem_reg[rp_reg].last);
    row_next      = row_reg;
    lflush_next   = (lflush_reg != 6'h00) ? lflush_reg - 6'h01 : 6'h00;
    fflush_next   = (fflush_reg != '0) ? fflush_reg - 32'h1 : '0;
    cyc_next      = cyc_reg + 32'h1;
    line_next     = line_reg;
    eol_seen_next = eol_seen_reg;
    if (end_of_line_pulse)
    begin
      cyc_next      = 32'h0;
      eol_seen_next = 1'b1;
      if (eol_seen_reg)
        line_next = cyc_reg + 32'h1; // [RULE1]
      lflush_next = k; // [RULE10] [RULE12]
      row_next    = row_reg + 16'h0001;
      if (frame_end)
      begin
        row_next    = 16'h0000;
        lflush_next = 6'h00;
        fflush_next = line_reg; // [RULE11]
        state_next  = ie_pkg::IE_FRAME_FLUSH;
      end
    end
    // Frame flush ends after one line time and an empty store
    if (state_reg == ie_pkg::IE_FRAME_FLUSH && fflush_reg == '0 && cnt_reg == '0)
      state_next = ie_pkg::IE_RUN;
  end

  // Registers of the stream logic, synchronous reset
  // Reset wins over the enable, so a frozen core still clears
  always_ff @(posedge clk)
  begin
    if (!rst_b) // [RULE15]
    begin
      state_reg    <= ie_pkg::IE_RUN;
      pipe_v_reg   <= '0;
      pipe_d_reg[0] <= '0;
      wp_reg       <= '0;
      rp_reg       <= '0;
      cnt_reg      <= '0;
      lines_reg    <= '0;
      row_reg      <= 16'h0000;
      lflush_reg   <= 6'h00;
      fflush_reg   <= 32'h0;
      cyc_reg      <= 32'h0;
      line_reg     <= 32'h0;
      eol_seen_reg <= 1'b0;
    end
    else if (ce) // [RULE16]
    begin
      state_reg    <= state_next;
      pipe_v_reg   <= pipe_v_next;
      pipe_d_reg[0] <= pipe_d_next[0];
      wp_reg       <= wp_next;
      rp_reg       <= rp_next;
      cnt_reg      <= cnt_next;
      lines_reg    <= lines_next;
      row_reg      <= row_next;
      lflush_reg   <= lflush_next;
      fflush_reg   <= fflush_next;
      cyc_reg      <= cyc_next;
      line_reg     <= line_next;
      eol_seen_reg <= eol_seen_next;
    end
  end

  // Line store array; no reset since occupancy is tracked separately
  always_ff @(posedge clk)
  begin
    if (in_fire)
      mem_reg[wp_reg] <= in_beat;
  end

  // Register port: writes, and read data one cycle later
  always_comb
  begin
    ctrl_next  = ctrl_reg;
    rows_next  = rows_reg;
    rdata_next = 32'h0;
    if (reg_wr && reg_addr == `IE_CTRL_OFF)
      ctrl_next = reg_wdata[3:0];
    if (reg_wr && reg_addr == `IE_ROWS_OFF)
      rows_next = reg_wdata[15:0];
    // Status word: state, store empty, latency lines and latency cycles
    if (reg_rd)
    begin
      case (reg_addr)
        `IE_CTRL_OFF: rdata_next = {28'h0, ctrl_reg};
        `IE_ROWS_OFF: rdata_next = {16'h0, rows_reg};
        `IE_LINE_OFF: rdata_next = line_reg;
        `IE_STAT_OFF: rdata_next = {10'h000, k, 5'h00, dl, 5'h00, cnt_reg == '0, state_reg};
        default:      rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ctrl_reg  <= `IE_CTRL_RST;
      rows_reg  <= `IE_ROWS_RST;
      rdata_reg <= 32'h0;
    end
    else if (ce)
    begin
      ctrl_reg  <= ctrl_next;
      rows_reg  <= rows_next;
      rdata_reg <= rdata_next;
    end
  end

  // Read data stands one cycle after the strobe, zero otherwise
  assign reg_rdata = rdata_reg;

  // Output buffer absorbs sink stalls before the pipe must stop
  ie_fifo #(
    .W     ($bits(ie_pkg::ie_beat_t)),
    .DEPTH (`IE_FIFO_DEPTH)
  ) u_out_fifo (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .in_p  (pipe_to_buf),
    .out_p (buf_to_out)
  );

  // Pins take the buffered beat apart; valid and ready pass straight through
  assign buf_to_out.ready    = m_axis_video_tready;
  assign m_axis_video_tvalid = buf_to_out.valid; // [RULE13]
  assign m_axis_video_tdata  = buf_to_out.data.pix;
  assign m_axis_video_tuser  = buf_to_out.data.user;
  assign m_axis_video_tlast  = buf_to_out.data.last;

  // Helper counts of accepted and delivered beats
  logic [31:0] nin_reg, nout_reg;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      nin_reg  <= 32'h0;
      nout_reg <= 32'h0;
    end
    else
    begin
      nin_reg  <= nin_reg + 32'(in_fire);
      nout_reg <= nout_reg + 32'(m_axis_video_tvalid && m_axis_video_tready);
    end
  end

  // Stream timing checks; all are off while reset is held
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_LINE_MEAS: assert property (end_of_line_pulse && eol_seen_reg // [RULE1]
    |=> line_reg == $past(cyc_reg) + 32'h1) else $error("line length wrong");
  AST_LAT_NR: assert property (ctrl_reg == 4'h1 |-> k == 6'd22 && dl == 3'd2) // [RULE2]
    else $error("noise latency wrong");
  AST_LAT_EE: assert property (ctrl_reg[1:0] == 2'b10 // [RULE3]
    |-> k == (ctrl_reg[2] ? 6'd23 : 6'd20)) else $error("edge latency wrong");
  AST_LAT_BOTH: assert property (ctrl_reg[1:0] == 2'b11 && !ctrl_reg[3] // [RULE4]
    |-> k == (ctrl_reg[2] ? 6'd27 : 6'd24) && dl == 3'd2) else $error("both latency wrong");
  AST_LAT_HP: assert property (ctrl_reg[1:0] == 2'b11 && ctrl_reg[3] // [RULE5]
    |-> k == (ctrl_reg[2] ? 6'd38 : 6'd35) && dl == 3'd4) else $error("fast latency wrong");
  AST_COUNT: assert property (nout_reg <= nin_reg) // [RULE6]
    else $error("more pixels out than in");
  AST_FULL: assert property (cnt_reg == (AW+1)'(MD) |-> !s_axis_video_tready) // [RULE8]
    else $error("ready while store full");
  AST_LINE_FLUSH: assert property (end_of_line_pulse && !frame_end // [RULE10]
    |=> (!s_axis_video_tready) [*8]) else $error("ready during line flush");
  AST_FRAME_FLUSH: assert property (frame_end // [RULE11]
    |=> state_reg == ie_pkg::IE_FRAME_FLUSH && !s_axis_video_tready)
    else $error("ready during frame flush");
  AST_FREEZE: assert property (!ce |=> $stable(cnt_reg) && $stable(state_reg)) // [RULE16]
    else $error("state moved without enable");
  AST_OVERHEAD: assert property (lflush_reg <= 6'd38) // [RULE12]
    else $error("line overhead too long");
  AST_READY_OPEN: assert property (ce && state_reg == ie_pkg::IE_RUN // [RULE9]
    && lflush_reg == 6'h00 && cnt_reg == '0 |-> s_axis_video_tready)
    else $error("ready closed while idle");

  // Main scenarios: frame drain, full store, fast build output, line flush
  COV_FRAME: cover property (frame_end ##[1:1000] state_reg == ie_pkg::IE_RUN);
  COV_FULL: cover property (cnt_reg == (AW+1)'(MD));
  COV_HP_OUT: cover property (ctrl_reg == 4'hF && m_axis_video_tvalid && m_axis_video_tready);
  COV_LINE_FLUSH: cover property (end_of_line_pulse && !frame_end ##1 !s_axis_video_tready);

endmodule : ie_core

// *** test/ie_stream_partner.sv ***
// Video stream source and sink model facing the enhancement core
// Assumes the bench owns clk and calls tasks just after a rising edge
module ie_stream_partner (
  input  wire logic        clk,
  input  wire logic        s_tready,
  output logic      [23:0] s_tdata,
  output logic             s_tuser,
  output logic             s_tlast,
  output logic             s_tvalid,
  output logic             m_tready
);
  timeunit 1ns;
  timeprecision 1ns;
  int               stall_pct = 0;
  ie_pkg::ie_beat_t exp_q[$];

  // Quiet source at time zero
  initial
  begin
    s_tdata  = 24'h000000;
    s_tuser  = 1'b0;
    s_tlast  = 1'b0;
    s_tvalid = 1'b0;
    m_tready = 1'b0;
  end

  // Sink throttles at random; 100 blocks it for good
  always @(posedge clk)
    m_tready <= ($urandom_range(99) >= stall_pct);

  // Source: each beat held until the edge that takes it
  task send_frame(input int rows, input int cols, input int idle_pct);
    ie_pkg::ie_beat_t b;
    logic             rdy;
    for (int r = 0; r < rows; r++)
      for (int c = 0; c < cols; c++)
      begin
        b.user = (r == 0 && c == 0);
        b.last = (c == cols - 1);
        b.pix  = 24'($urandom);
        while ($urandom_range(99) < idle_pct) // Gaps stand for blanking
        begin
          s_tvalid <= 1'b0;
          s_tdata  <= ~s_tdata; // Idle data keeps moving, never a stale beat
          @(posedge clk);
        end
        s_tvalid <= 1'b1;
        s_tdata  <= b.pix;
        s_tuser  <= b.user;
        s_tlast  <= b.last;
        do
        begin
          @(negedge clk);
          rdy = s_tready;
          @(posedge clk);
        end
        while (!rdy);
        exp_q.push_back(b);
      end
    s_tvalid <= 1'b0;
  endtask : send_frame

  // Drop valid after an aborted frame
  task quiet();
    s_tvalid <= 1'b0;
  endtask : quiet
endmodule : ie_stream_partner

// *** test/image_enhance_stream_timing_tb_top.sv ***
// Self-checking bench for the enhancement stream timing core
// Assumes the partner model drives both stream sides
`include "ie_regs.svh"
module image_enhance_stream_timing_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [23:0] s_data, m_data;
  logic s_user, s_last, s_valid, s_ready, m_user, m_last, m_valid, m_ready;
  logic rd_seen = 1'b0;
  logic [31:0] rd_q[$];
  int errors = 0, samples_checked = 0;
  int cur_k, cur_rows, line_exp, row_cnt, low_cnt;
  bit flush_chk = 0, armed = 0;
  logic [3:0] modes [6] = '{4'h1, 4'h2, 4'h6, 4'h7, 4'hB, 4'hF};

  ie_core i_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .s_axis_video_tdata(s_data), .s_axis_video_tuser(s_user),
    .s_axis_video_tlast(s_last), .s_axis_video_tvalid(s_valid),
    .s_axis_video_tready(s_ready), .m_axis_video_tdata(m_data),
    .m_axis_video_tuser(m_user), .m_axis_video_tlast(m_last),
    .m_axis_video_tvalid(m_valid), .m_axis_video_tready(m_ready));

  ie_stream_partner i_part (.clk(clk), .s_tready(s_ready), .s_tdata(s_data),
    .s_tuser(s_user), .s_tlast(s_last), .s_tvalid(s_valid), .m_tready(m_ready));

  // 100 MHz clock
  always #5 clk = ~clk;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task finish_test();
    $display("errors %0d, samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // Pipe figure per control word
  function automatic int k_of(input logic [3:0] m);
    if (m[0] && m[1])
      return 24 + (m[2] ? 3 : 0) + (m[3] ? 11 : 0);
    if (m[1])
      return 20 + (m[2] ? 3 : 0);
    return 22;
  endfunction : k_of

  task reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : reg_write

  task reg_read(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    rd_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : reg_read

  // Mode and frame height, plus the figures the monitors expect
  task set_mode(input logic [3:0] m, input int rows);
    reg_write(`IE_CTRL_OFF, {28'h0000000, m});
    reg_write(`IE_ROWS_OFF, 32'(rows));
    cur_k    = k_of(m);
    cur_rows = rows;
    line_exp = 8 + cur_k;
    row_cnt  = 0;
  endtask : set_mode

  // Wait for every noted pixel, then valid must fall
  task drain();
    for (int i = 0; i < 4000 && i_part.exp_q.size() > 0; i++)
      @(posedge clk);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(32'(i_part.exp_q.size()), 32'h00000000);
    check(32'(m_valid), 32'h00000000);
    @(posedge clk);
  endtask : drain

  // Read data stands one cycle after the strobe
  always @(posedge clk)
    rd_seen <= reg_rd & ce;

  // Output and flush monitor, sampled mid-cycle where all is settled
  always @(negedge clk)
  begin
    if (m_valid === 1'b1 && m_ready === 1'b1)
      check({6'h00, m_user, m_last, m_data}, (i_part.exp_q.size() > 0) ?
        {6'h00, i_part.exp_q.pop_front()} : 32'hFFFFFFFF);
    if (rd_seen)
      check(reg_rdata, rd_q.pop_front());
    if (flush_chk && s_valid && s_ready && s_last)
    begin
      row_cnt++;
      low_cnt = 0;
      armed = 1;
    end
    else if (flush_chk && armed && !s_ready)
      low_cnt++;
    else if (flush_chk && armed)
    begin
      armed = 0;
      if (row_cnt % cur_rows == 0)
        check(32'(low_cnt >= line_exp), 32'h00000001);
      else
        check(32'(low_cnt), 32'(cur_k));
    end
  end

  // Watchdog well beyond the expected six thousand cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    errors++;
    $display("ERROR at %0t: seen %h expected %h", $time, 0, 1);
    finish_test();
  end

  initial
  begin
    void'($urandom(60));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    reg_read(`IE_CTRL_OFF, 32'h00000003);
    reg_read(`IE_ROWS_OFF, 32'h00000020);
    reg_read(8'h10, 32'h00000000);
    $display("test reset values done");
    // Every control word: status shows its lines and pipe figure
    for (int m = 0; m < 16; m++)
    begin
      reg_write(`IE_CTRL_OFF, 32'(m));
      reg_read(`IE_CTRL_OFF, 32'(m));
      reg_read(`IE_STAT_OFF, {10'h000, 6'(k_of(4'(m))), 5'h00,
        (m[3:0] ==? 4'b1?11) ? 3'h4 : 3'h2, 8'h04});
    end
    $display("test latency modes done");
    set_mode(4'h3, 4);
    flush_chk = 1;
    i_part.send_frame(4, 8, 0);
    drain();
    reg_read(`IE_LINE_OFF, 32'(8 + 24));
    $display("test continuous frame done");
    // Random gaps and stalls in several modes
    foreach (modes[i])
    begin
      set_mode(modes[i], 4);
      i_part.stall_pct = 30;
      i_part.send_frame(4, 8, 30);
      drain();
    end
    $display("test throttled modes done");
    flush_chk = 0;
    set_mode(4'h3, 80);
    i_part.stall_pct = 100;
    fork
      i_part.send_frame(80, 8, 0);
      begin
        repeat (3000) @(posedge clk);
        @(negedge clk);
        check(32'(s_ready), 32'h00000000);
        check(32'(m_valid), 32'h00000001);
        @(posedge clk);
        i_part.stall_pct = 0;
      end
    join
    drain();
    $display("test full buffers done");
    set_mode(4'h3, 4);
    fork
      i_part.send_frame(4, 8, 0);
      begin
        repeat (100) @(posedge clk);
        ce <= 1'b0;
        @(negedge clk);
        check(32'(s_ready), 32'h00000000);
        check(32'(m_valid), 32'h00000000);
        repeat (4) @(posedge clk);
        ce <= 1'b1;
      end
    join
    drain();
    $display("test clock enable done");
    reg_write(`IE_CTRL_OFF, 32'h00000007);
    fork
      i_part.send_frame(4, 8, 0);
    join_none
    repeat (20) @(posedge clk);
    disable fork;
    i_part.quiet();
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    i_part.exp_q.delete();
    @(negedge clk);
    check(32'(m_valid), 32'h00000000);
    check(32'(s_ready), 32'h00000001);
    @(posedge clk);
    reg_read(`IE_CTRL_OFF, 32'h00000003);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule : image_enhance_stream_timing_tb_top
